//--- tb.sv
// Bench: host model drives, reads scored in order.
// Read data assumed one cycle after its strobe.
`timescale 1ns/1ns
module tb;
    reg i_sys_clk = 1'b0, i_rst = 1'b1, seen = 1'b0;
    reg [7:0] i_rx_data, i_int_ident, i_line_cond, i_modem_in, i_tx_fill;
    reg [7:0] i_rx_fill, e;
    reg [7:0] q [$];
    integer seed = 11588, bad_count = 0, checks = 0;
    wire [3:0] i_addr;
    wire i_wr, i_rd, o_rx_pop, o_tx_push, o_ident_read, o_fctl_wr;
    wire o_tx_fifo_reset, o_rx_fifo_reset;
    wire [15:0] o_baud_divisor;
    wire [7:0] i_wdata, o_rdata, o_tx_data, o_fifo_control, o_int_enable;
    wire [7:0] o_line_format, o_modem_ctl, o_scratch, o_extra_feature;
    wire [7:0] o_enh_feature, o_resume_first, o_resume_second, o_pause_first;
    wire [7:0] o_pause_second, o_halt_resume, o_trig_levels;
    always #20 i_sys_clk = ~i_sys_clk;
    ursel_host_model h (.i_sys_clk(i_sys_clk), .o_addr(i_addr), .o_wr(i_wr),
        .o_rd(i_rd), .o_wdata(i_wdata));
    ursel_regbank u_dut (.*);
    task rd(input [3:0] a, input [7:0] x);
        q.push_back(x);
        h.acc(2'h1, a, 8'h00);
    endtask
    always @(negedge i_sys_clk) begin
        checks = checks + seen;
        e = seen ? q.pop_front() : e;
        if (seen && o_rdata !== e) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t got %h exp %h", $time, o_rdata, e);
        end
        seen <= i_rd;
    end
    task complete_run;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0 && q.size() == 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        {i_rx_data, i_int_ident, i_line_cond, i_modem_in} = $random(seed);
        {i_tx_fill, i_rx_fill, e} = $random(seed);
        #62 i_rst = 1'b0;
        h.acc(2'h2, 4'h3, 8'h03);
        h.acc(2'h2, 4'h0, i_modem_in);
        checks = checks + 1;
        if (o_tx_data !== i_modem_in || o_tx_push !== 1'b1) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t got %h exp %h", $time,
                o_tx_data, i_modem_in);
        end
        rd(4'h0, i_rx_data);
        rd(4'h2, i_int_ident);
        h.acc(2'h2, 4'h2, 8'hc7);
        checks = checks + 1;
        if (o_fifo_control !== 8'hc7 || o_tx_fifo_reset !== 1'b1) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t got %h exp %h", $time,
                o_fifo_control, 8'hc7);
        end
        h.acc(2'h0, 4'h0, 8'h00);
        h.acc(2'h0, 4'h0, 8'h00);
        rd(4'h5, i_line_cond);
        rd(4'h8, i_tx_fill);
        h.acc(2'h2, 4'h1, 8'hff);
        rd(4'h1, 8'h0f);
        h.acc(2'h2, 4'h4, 8'he5);
        rd(4'h4, 8'h00);
        h.acc(2'h2, 4'h3, 8'h80);
        rd(4'h0, 8'h01);
        h.acc(2'h2, 4'h0, 8'h14);
        h.acc(2'h2, 4'h3, 8'hbf);
        h.acc(2'h2, 4'h2, 8'h10);
        rd(4'h0, 8'h00);
        h.acc(2'h2, 4'h3, 8'h03);
        h.acc(2'h2, 4'h4, 8'h84);
        rd(4'h4, 8'h84);
        h.acc(2'h2, 4'h6, i_rx_fill);
        rd(4'h6, i_rx_fill);
        h.acc(2'h0, 4'h0, 8'h00);
        complete_run;
    end
endmodule // tb

//--- ursel_host_model.sv
// Host side of the register bus: one-cycle read and write strobes.
// Calls start just after a rising edge; idle bus shows inverted leftovers.
`timescale 1ns/1ns
module ursel_host_model (input wire i_sys_clk, output reg [3:0] o_addr,
    output reg o_wr, output reg o_rd, output reg [7:0] o_wdata);
    initial {o_addr, o_wr, o_rd, o_wdata} = 14'h0000;
    task acc(input [1:0] k, input [3:0] a, input [7:0] d);
        {o_wr, o_rd} = k;
        {o_addr, o_wdata} = (k != 2'h0) ? {a, d} : ~{o_addr, o_wdata};
        @(posedge i_sys_clk);
        #2;
    endtask
endmodule // ursel_host_model

//--- ursel_map.vh
// Register offsets, field positions and reset values of the register bank.
// Included by ursel_regbank.v only.
`ifndef URSEL_MAP_VH
`define URSEL_MAP_VH
`define URSEL_A_HOLD 4'h0
`define URSEL_A_IEN 4'h1
`define URSEL_A_FCTL 4'h2
`define URSEL_A_LFMT 4'h3
`define URSEL_A_MCTL 4'h4
`define URSEL_A_LCOND 4'h5
`define URSEL_A_MIN 4'h6
`define URSEL_A_SCR 4'h7
`define URSEL_A_TXLV 4'h8
`define URSEL_A_RXLV 4'h9
`define URSEL_A_XFC 4'hf
`define URSEL_A_DIVL 4'h0
`define URSEL_A_DIVH 4'h1
`define URSEL_A_EFC 4'h2
`define URSEL_A_RES1 4'h4
`define URSEL_A_RES2 4'h5
`define URSEL_A_PAU1 4'h6
`define URSEL_A_PAU2 4'h7
`define URSEL_A_HRL 4'h6
`define URSEL_A_TRL 4'h7
`define URSEL_ENH_KEY 8'hbf
`define URSEL_DLE_BIT 7
`define URSEL_EFE_BIT 4
`define URSEL_TRE_BIT 2
`define URSEL_CPS_BIT 7
`define URSEL_IEN_ENH_MASK 8'hf0
`define URSEL_FCTL_ENH_MASK 8'h30
`define URSEL_MCTL_ENH_MASK 8'he4
`define URSEL_MCTL_RSV_MASK 8'h09
`define URSEL_FCTL_RSV_MASK 8'h08
`define URSEL_RST_VAL 8'h00
`define URSEL_DIV_RST 16'h0001
`endif

//--- ursel_monitor.sv
// Checker on the register bank ports.
// Bound to every ursel_regbank; one clock domain.
`timescale 1ns/1ns
module ursel_monitor (input wire i_sys_clk, input wire i_rst,
    input wire [3:0] i_addr, input wire i_wr, input wire i_rd,
    input wire [7:0] i_wdata, input wire o_rx_pop, input wire o_tx_push,
    input wire o_fctl_wr, input wire o_tx_fifo_reset,
    input wire [7:0] o_line_format, input wire [7:0] o_modem_ctl,
    input wire [7:0] o_enh_feature, input wire [15:0] o_baud_divisor);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    wire gen0 = i_addr == 4'h0 && !o_line_format[7];
    chk_lf_write: assert property (i_wr && i_addr == 4'h3 |=>
        o_line_format == $past(i_wdata)) else $error("format lost");
    chk_tx_push: assert property (i_wr && gen0 |=> o_tx_push)
        else $error("no push");
    chk_rx_pop: assert property (i_rd && gen0 |=> o_rx_pop)
        else $error("no pop");
    chk_pop_src: assert property (o_rx_pop |-> $past(i_rd) &&
        $past(gen0)) else $error("stray pop");
    chk_div_low: assert property (i_wr && !gen0 && i_addr == 4'h0 &&
        o_line_format != 8'hbf |=> !o_tx_push &&
        o_baud_divisor[7:0] == $past(i_wdata)) else $error("divisor");
    chk_cps_lock: assert property (!o_enh_feature[4] |=>
        $stable(o_modem_ctl[7])) else $error("prescale moved");
    chk_mctl_rsv: assert property ((o_modem_ctl & 8'h09) == 8'h00)
        else $error("reserved set");
    chk_fifo_rst: assert property (i_wr && i_addr == 4'h2 &&
        !o_line_format[7] |=> o_fctl_wr &&
        o_tx_fifo_reset == $past(i_wdata[2])) else $error("fifo ctl");
    cover property (o_rx_pop);
    cover property (o_tx_push);
    cover property (o_fctl_wr);
endmodule // ursel_monitor
bind ursel_regbank ursel_monitor u_mon (.*);

//--- ursel_regbank.v
// Register bank with address selection for a single serial channel.
// Assumes a host bridge on i_sys_clk delivering one-cycle read/write
// strobes; the serial engine supplies status, levels and FIFO data.
`timescale 1ns/1ns
`include "ursel_map.vh"

// Overview of operation
// [R01] Address 0: read pops receive FIFO, write pushes transmit FIFO.
// [R02] Address 2: read gives interrupt ident, write sets FIFO control.
// [R03] Line status and modem status are read only.
// [R04] Transmit and receive fill-level registers are read only.
// [R05] Prescaler select bit writable only while enhanced functions enabled.
// [R06] Halt/resume and trigger registers need enhanced and trigger enables.
// [R07] Divisor bytes selected only while divisor latch enable is one.
// [R08] Enhanced and flow characters selected only when line format is 0xBF.
// [R09] Interrupt enable: eight enables, CTS change down to receive data.
// [R10] FIFO control decodes trigger levels, FIFO resets and FIFO enable.
// [R11] Line format: latch enable, break, parity, stop and word length.
// [R12] Modem control fields; bits 3 and 0 reserved.
// [R13] Host programs divisor 20, 10, 5 at 3.072 MHz for 9600-38400.
// [R14] General set reachable only while divisor latch enable is zero.
// [R15] Enhanced bits accept writes only with enhanced functions enabled.
// [R16] Divisor pair reachable when latch enable set and format not 0xBF.
// [R17] Host waits two reference periods after a FIFO reset.
// [R18] Writes to read-only or unselected places change nothing; reserved 0.
module ursel_regbank (
    input wire i_sys_clk,
    input wire i_rst,
    input wire [3:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_wdata,
    input wire [7:0] i_rx_data,
    input wire [7:0] i_int_ident,
    input wire [7:0] i_line_cond,
    input wire [7:0] i_modem_in,
    input wire [7:0] i_tx_fill,
    input wire [7:0] i_rx_fill,
    output reg [7:0] o_rdata,
    output reg o_rx_pop,
    output reg o_tx_push,
    output reg [7:0] o_tx_data,
    output reg o_ident_read,
    output reg o_fctl_wr,
    output reg [7:0] o_fifo_control,
    output reg o_tx_fifo_reset,
    output reg o_rx_fifo_reset,
    output reg [7:0] o_int_enable,
    output reg [7:0] o_line_format,
    output reg [7:0] o_modem_ctl,
    output reg [7:0] o_scratch,
    output reg [7:0] o_extra_feature,
    output reg [15:0] o_baud_divisor,
    output reg [7:0] o_enh_feature,
    output reg [7:0] o_resume_first,
    output reg [7:0] o_resume_second,
    output reg [7:0] o_pause_first,
    output reg [7:0] o_pause_second,
    output reg [7:0] o_halt_resume,
    output reg [7:0] o_trig_levels
);

    wire enh_key = (o_line_format == `URSEL_ENH_KEY); // R08
    wire dle = o_line_format[`URSEL_DLE_BIT];
    wire efe = o_enh_feature[`URSEL_EFE_BIT];

    wire sel_gen = !dle; // R14
    wire sel_div = dle && !enh_key; // R07 R16
    wire sel_tt = sel_gen && efe && o_modem_ctl[`URSEL_TRE_BIT]; // R06
    wire wg = i_wr && sel_gen;

    // Enhanced bits keep their old value unless unlocked
    wire [7:0] ien_m = efe ? 8'hff : ~`URSEL_IEN_ENH_MASK; // R15
    wire [7:0] fc_m = efe ? 8'hff : ~`URSEL_FCTL_ENH_MASK; // R15
    wire [7:0] mc_m = efe ? 8'hff : ~`URSEL_MCTL_ENH_MASK; // R05 R15

    // Masked next values; reserved bits forced to zero
    wire [7:0] ien_d = (i_wdata & ien_m) | (o_int_enable & ~ien_m); // R09
    wire [7:0] fctl_d = ((i_wdata & fc_m) | (o_fifo_control & ~fc_m))
        & ~`URSEL_FCTL_RSV_MASK; // R10 R18
    wire [7:0] mctl_d = ((i_wdata & mc_m) | (o_modem_ctl & ~mc_m))
        & ~`URSEL_MCTL_RSV_MASK; // R05 R12

    reg [7:0] rd_d;

    // Unmapped and unselected reads give zero
    always @* begin
        rd_d = 8'h00; // R18
        if (enh_key) begin
            case (i_addr) // R08
                `URSEL_A_LFMT: rd_d = o_line_format; // R11
                `URSEL_A_EFC: rd_d = o_enh_feature;
                `URSEL_A_RES1: rd_d = o_resume_first;
                `URSEL_A_RES2: rd_d = o_resume_second;
                `URSEL_A_PAU1: rd_d = o_pause_first;
                `URSEL_A_PAU2: rd_d = o_pause_second;
                default: rd_d = 8'h00;
            endcase
        end else if (sel_div) begin
            case (i_addr) // R07
                `URSEL_A_DIVL: rd_d = o_baud_divisor[7:0];
                `URSEL_A_DIVH: rd_d = o_baud_divisor[15:8];
                `URSEL_A_LFMT: rd_d = o_line_format; // R11
                default: rd_d = 8'h00;
            endcase
        end else begin
            case (i_addr)
                `URSEL_A_HOLD: rd_d = i_rx_data; // R01
                `URSEL_A_IEN: rd_d = o_int_enable; // R09
                `URSEL_A_FCTL: rd_d = i_int_ident; // R02
                `URSEL_A_LFMT: rd_d = o_line_format;
                `URSEL_A_MCTL: rd_d = o_modem_ctl;
                `URSEL_A_LCOND: rd_d = i_line_cond; // R03
                `URSEL_A_MIN: rd_d = sel_tt ? o_halt_resume : i_modem_in;
                `URSEL_A_SCR: rd_d = sel_tt ? o_trig_levels : o_scratch;
                `URSEL_A_TXLV: rd_d = i_tx_fill; // R04
                `URSEL_A_RXLV: rd_d = i_rx_fill; // R04
                `URSEL_A_XFC: rd_d = o_extra_feature;
                default: rd_d = 8'h00;
            endcase
        end
    end

    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= `URSEL_RST_VAL;
            o_rx_pop <= 1'b0;
            o_tx_push <= 1'b0;
            o_tx_data <= `URSEL_RST_VAL;
            o_ident_read <= 1'b0;
            o_fctl_wr <= 1'b0;
            o_fifo_control <= `URSEL_RST_VAL;
            o_tx_fifo_reset <= 1'b0;
            o_rx_fifo_reset <= 1'b0;
            o_int_enable <= `URSEL_RST_VAL;
            o_line_format <= `URSEL_RST_VAL;
            o_modem_ctl <= `URSEL_RST_VAL;
            o_scratch <= `URSEL_RST_VAL;
            o_extra_feature <= `URSEL_RST_VAL;
            // Divisor starts at one so the baud clock never stalls
            o_baud_divisor <= `URSEL_DIV_RST;
            o_enh_feature <= `URSEL_RST_VAL;
            o_resume_first <= `URSEL_RST_VAL;
            o_resume_second <= `URSEL_RST_VAL;
            o_pause_first <= `URSEL_RST_VAL;
            o_pause_second <= `URSEL_RST_VAL;
            o_halt_resume <= `URSEL_RST_VAL;
            o_trig_levels <= `URSEL_RST_VAL;
        end else begin
            o_rx_pop <= 1'b0;
            o_tx_push <= 1'b0;
            o_ident_read <= 1'b0;
            o_fctl_wr <= 1'b0;
            o_tx_fifo_reset <= 1'b0;
            o_rx_fifo_reset <= 1'b0;

            // Read data held until the next read
            if (i_rd) begin
                o_rdata <= rd_d;
                o_rx_pop <= sel_gen && !enh_key
                    && i_addr == `URSEL_A_HOLD;
                o_ident_read <= sel_gen && !enh_key
                    && i_addr == `URSEL_A_FCTL;
            end

            // 0xBF has bit 7 set, so general-set writes never overlap it
            if (wg) begin
                case (i_addr)
                    `URSEL_A_HOLD: begin // R01
                        o_tx_push <= 1'b1;
                        o_tx_data <= i_wdata;
                    end
                    `URSEL_A_IEN: begin // R09
                        o_int_enable <= ien_d;
                    end
                    `URSEL_A_FCTL: begin // R02 R10
                        o_fctl_wr <= 1'b1;
                        o_fifo_control <= fctl_d;
                        o_tx_fifo_reset <= i_wdata[2];
                        o_rx_fifo_reset <= i_wdata[1];
                    end
                    `URSEL_A_MCTL: begin // R12
                        o_modem_ctl <= mctl_d;
                    end
                    `URSEL_A_MIN: if (sel_tt) o_halt_resume <= i_wdata; // R06
                    `URSEL_A_SCR: begin
                        if (sel_tt)
                            o_trig_levels <= i_wdata; // R06
                        else
                            o_scratch <= i_wdata;
                    end
                    `URSEL_A_XFC: o_extra_feature <= i_wdata;
                    default: ; // R03 R04 R18
                endcase
            end

            // Line format stays writable in every set so software can leave
            if (i_wr && i_addr == `URSEL_A_LFMT)
                o_line_format <= i_wdata; // R11

            if (i_wr && sel_div) begin
                case (i_addr) // R07 R16
                    `URSEL_A_DIVL: o_baud_divisor[7:0] <= i_wdata;
                    `URSEL_A_DIVH: o_baud_divisor[15:8] <= i_wdata;
                    default: ;
                endcase
            end

            if (i_wr && enh_key) begin
                case (i_addr) // R08
                    `URSEL_A_EFC: o_enh_feature <= i_wdata;
                    `URSEL_A_RES1: o_resume_first <= i_wdata;
                    `URSEL_A_RES2: o_resume_second <= i_wdata;
                    `URSEL_A_PAU1: o_pause_first <= i_wdata;
                    `URSEL_A_PAU2: o_pause_second <= i_wdata;
                    default: ;
                endcase
            end
        end
    end
endmodule // ursel_regbank
